// [hdl/wuim_pkg.sv]
// constants, bus carriers and state codes of the wake-up interrupt manager
package wuim_pkg;

  localparam int LINE_COUNT = 16;
  localparam int BYTE_W = 8;
  localparam int ADR_W = 10;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;
  localparam int WORD_LSB = 2;
  localparam int IDX_W = ADR_W - WORD_LSB;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_LINE_STATE_HIGH = 8'hF7;
  localparam logic [IDX_W-1:0] IDX_LINE_STATE_LOW = 8'hF8;
  localparam logic [IDX_W-1:0] IDX_CONTROL = 8'hF9;
  localparam logic [IDX_W-1:0] IDX_MASK_HIGH = 8'hFA;
  localparam logic [IDX_W-1:0] IDX_MASK_LOW = 8'hFB;
  localparam logic [IDX_W-1:0] IDX_POL_HIGH = 8'hFC;
  localparam logic [IDX_W-1:0] IDX_POL_LOW = 8'hFD;
  localparam logic [IDX_W-1:0] IDX_PEND_HIGH = 8'hFE;
  localparam logic [IDX_W-1:0] IDX_PEND_LOW = 8'hFF;

  // control register fields
  localparam int CTRL_WAKE_MODE_BIT = 0;
  localparam int CTRL_SRC_SEL_BIT = 1;
  localparam int CTRL_STOP_BIT = 2;

  localparam logic [LINE_COUNT-1:0] LINES_RESET = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
  localparam logic [DAT_W-1:0] READ_ZERO = 32'h0000_0000;

  // one more than the clock cycles between a good stop sequence and the stop request
  localparam int STOP_ENTRY_CYCLES = 4;
  localparam int ENTRY_CNT_W = 3;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [SEL_W-1:0] sel;
    logic [DAT_W-1:0] dat;
  } wuim_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [DAT_W-1:0] dat;
  } wuim_wb_rsp_t;

  typedef enum logic [2:0] {
    STOP_IDLE = 3'b000,
    STOP_GOT_ONE = 3'b001,
    STOP_GOT_ZERO = 3'b010,
    STOP_ENTERING = 3'b011,
    STOP_STOPPED = 3'b100
  } wuim_stop_state_t;

endpackage : wuim_pkg

// [hdl/wuim_pin_sync.sv]
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module wuim_pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pinAsync,
  output logic [WIDTH-1:0] pinLevel,
  output logic [WIDTH-1:0] pinRise,
  output logic [WIDTH-1:0] pinFall
);
  import wuim_pkg::*;

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;
  logic [WIDTH-1:0] level_r;
  logic [WIDTH-1:0] level_nxt;
  logic [WIDTH-1:0] rise_r;
  logic [WIDTH-1:0] fall_r;

  // a level change counts only once stages two and three agree
  assign level_nxt = (~(stage2_r ^ stage3_r) & stage3_r) | ((stage2_r ^ stage3_r) & level_r);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stage1_r <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
      level_r <= '0;
    end else begin
      stage1_r <= pinAsync;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      level_r <= level_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rise_r <= '0;
      fall_r <= '0;
    end else begin
      rise_r <= level_nxt & ~level_r;
      fall_r <= ~level_nxt & level_r;
    end
  end

  assign pinLevel = level_r;
  assign pinRise = rise_r;
  assign pinFall = fall_r;

endmodule : wuim_pin_sync
`default_nettype wire

// [hdl/wuim_stop_seq.sv]
// recogniser of the three-write stop request and stop state tracker
`timescale 1ns/1ps
`default_nettype none
module wuim_stop_seq (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ctrlWrite,
  input wire logic ctrlStopData,
  input wire logic otherWrite,
  input wire logic entryAllowed,
  input wire logic wakeEvent,
  output logic stopBit,
  output logic stopRequest
);
  import wuim_pkg::*;

  wuim_stop_state_t state_r;
  wuim_stop_state_t state_nxt;
  logic [ENTRY_CNT_W-1:0] entryCnt_r;
  logic stopBit_r;
  logic stopRequest_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      STOP_IDLE: begin
        if (ctrlWrite && ctrlStopData && !otherWrite) begin
          state_nxt = STOP_GOT_ONE;
        end
      end
      STOP_GOT_ONE: begin
        if (otherWrite) begin
          state_nxt = STOP_IDLE;
        end else if (ctrlWrite) begin
          state_nxt = ctrlStopData ? STOP_GOT_ONE : STOP_GOT_ZERO;
        end
      end
      STOP_GOT_ZERO: begin
        if (otherWrite) begin
          state_nxt = STOP_IDLE;
        end else if (ctrlWrite) begin
          state_nxt = (ctrlStopData && entryAllowed) ? STOP_ENTERING : STOP_IDLE;
        end
      end
      STOP_ENTERING: begin
        if (otherWrite || ctrlWrite || wakeEvent) begin
          state_nxt = STOP_IDLE;
        end else if (entryCnt_r == ENTRY_CNT_W'(STOP_ENTRY_CYCLES - 1)) begin
          state_nxt = STOP_STOPPED;
        end
      end
      STOP_STOPPED: begin
        if (wakeEvent) begin
          state_nxt = STOP_IDLE;
        end
      end
      default: begin
        state_nxt = STOP_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= STOP_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || state_nxt != STOP_ENTERING) begin
      entryCnt_r <= '0;
    end else begin
      entryCnt_r <= entryCnt_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stopBit_r <= 1'b0;
      stopRequest_r <= 1'b0;
    end else begin
      stopBit_r <= (state_nxt == STOP_GOT_ONE) || (state_nxt == STOP_ENTERING)
                   || (state_nxt == STOP_STOPPED);
      stopRequest_r <= (state_nxt == STOP_STOPPED);
    end
  end

  assign stopBit = stopBit_r;
  assign stopRequest = stopRequest_r;

endmodule : wuim_stop_seq
`default_nettype wire

// [hdl/wuim_manager.sv]
// wake-up and interrupt manager: registers, line capture and channel merge
`timescale 1ns/1ps
`default_nettype none
module wuim_manager (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire wuim_pkg::wuim_wb_req_t wbReq,
  output wuim_pkg::wuim_wb_rsp_t wbRsp,
  input wire logic [wuim_pkg::LINE_COUNT-1:0] wakeLinePins,
  input wire logic singleExtIrqPin,
  input wire logic extRegWrite,
  output logic sharedExtIrqChannel,
  output logic wakeEventOut,
  output logic resetClockUnitStopReq
);
  import wuim_pkg::*;

  function automatic logic regHit(
    input logic [ADR_W-1:0] adr,
    input logic [IDX_W-1:0] idx
  );
    regHit = (adr[ADR_W-1:WORD_LSB] == idx);
  endfunction : regHit

  // one byte of a sixteen-line field, the high half holds lines 15:8
  function automatic logic [BYTE_W-1:0] lineByte(
    input logic [LINE_COUNT-1:0] lines,
    input logic high
  );
    if (high) begin
      lineByte = lines[LINE_COUNT-1:BYTE_W];
    end else begin
      lineByte = lines[BYTE_W-1:0];
    end
  endfunction : lineByte

  // replace one byte of a sixteen-line field
  function automatic logic [LINE_COUNT-1:0] mergeByte(
    input logic [LINE_COUNT-1:0] lines,
    input logic [BYTE_W-1:0] value,
    input logic high
  );
    mergeByte = lines;
    if (high) begin
      mergeByte[LINE_COUNT-1:BYTE_W] = value;
    end else begin
      mergeByte[BYTE_W-1:0] = value;
    end
  endfunction : mergeByte

  // bus slave state
  logic busReq;
  logic ack_r;
  logic commit;
  logic busWrite;
  logic laneWrite;
  logic [BYTE_W-1:0] wrByte;
  logic [DAT_W-1:0] rdData_r;
  logic [DAT_W-1:0] rdMux;

  // register hits
  logic hitCtrl;
  logic hitMaskH;
  logic hitMaskL;
  logic hitPolH;
  logic hitPolL;
  logic hitPendH;
  logic hitPendL;
  logic hitStateH;
  logic hitStateL;

  // register contents
  logic [LINE_COUNT-1:0] lineMask_r;
  logic [LINE_COUNT-1:0] linePolarity_r;
  logic [LINE_COUNT-1:0] linePending_r;
  logic [LINE_COUNT-1:0] linePending_nxt;
  logic [LINE_COUNT-1:0] pendingSw;
  logic channelSourceSelect_r;
  logic wakeModeSelect_r;

  // line capture
  logic [LINE_COUNT-1:0] lineLevel;
  logic [LINE_COUNT-1:0] lineRise;
  logic [LINE_COUNT-1:0] lineFall;
  logic [LINE_COUNT-1:0] hwSet;
  logic polarityWriting;
  logic extPinLevel;

  // merge and stop
  logic [LINE_COUNT-1:0] unmaskedPending;
  logic anyUnmasked;
  logic entryAllowed;
  logic wakeEvent;
  logic channelLevel;
  logic clearGap_r;
  logic channelIrq_r;
  logic wakeEventOut_r;
  logic stopBit;
  logic stopRequest;
  logic otherWrite;

  // write strobes, one for each writable register
  logic wrCtrl;
  logic wrMaskH;
  logic wrMaskL;
  logic wrPolH;
  logic wrPolL;
  logic wrPendH;
  logic wrPendL;

  // classic Wishbone: ack one cycle after the request, write at the ack edge
  assign busReq = wbReq.cyc & wbReq.stb;
  assign commit = busReq & ack_r;
  assign busWrite = commit & wbReq.we;
  assign laneWrite = busWrite & wbReq.sel[0];
  assign wrByte = wbReq.dat[BYTE_W-1:0];

  assign hitCtrl = regHit(wbReq.adr, IDX_CONTROL);
  assign hitMaskH = regHit(wbReq.adr, IDX_MASK_HIGH);
  assign hitMaskL = regHit(wbReq.adr, IDX_MASK_LOW);
  assign hitPolH = regHit(wbReq.adr, IDX_POL_HIGH);
  assign hitPolL = regHit(wbReq.adr, IDX_POL_LOW);
  assign hitPendH = regHit(wbReq.adr, IDX_PEND_HIGH);
  assign hitPendL = regHit(wbReq.adr, IDX_PEND_LOW);
  assign hitStateH = regHit(wbReq.adr, IDX_LINE_STATE_HIGH);
  assign hitStateL = regHit(wbReq.adr, IDX_LINE_STATE_LOW);

  assign wrCtrl = laneWrite & hitCtrl;
  assign wrMaskH = laneWrite & hitMaskH;
  assign wrMaskL = laneWrite & hitMaskL;
  assign wrPolH = laneWrite & hitPolH;
  assign wrPolL = laneWrite & hitPolL;
  assign wrPendH = laneWrite & hitPendH;
  assign wrPendL = laneWrite & hitPendL;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= busReq & ~ack_r;
    end
  end

  always_comb begin
    rdMux = READ_ZERO;
    if (hitCtrl) begin
      rdMux[CTRL_WAKE_MODE_BIT] = wakeModeSelect_r;
      rdMux[CTRL_SRC_SEL_BIT] = channelSourceSelect_r;
      rdMux[CTRL_STOP_BIT] = stopBit;
    end else if (hitMaskH) begin
      rdMux[BYTE_W-1:0] = lineByte(lineMask_r, 1'b1);
    end else if (hitMaskL) begin
      rdMux[BYTE_W-1:0] = lineByte(lineMask_r, 1'b0);
    end else if (hitPolH) begin
      rdMux[BYTE_W-1:0] = lineByte(linePolarity_r, 1'b1);
    end else if (hitPolL) begin
      rdMux[BYTE_W-1:0] = lineByte(linePolarity_r, 1'b0);
    end else if (hitPendH) begin
      rdMux[BYTE_W-1:0] = lineByte(linePending_r, 1'b1);
    end else if (hitPendL) begin
      rdMux[BYTE_W-1:0] = lineByte(linePending_r, 1'b0);
    end else if (hitStateH) begin
      rdMux[BYTE_W-1:0] = lineByte(lineLevel, 1'b1);
    end else if (hitStateL) begin
      rdMux[BYTE_W-1:0] = lineByte(lineLevel, 1'b0);
    end
  end

  // read data captured in the cycle before ack, held while ack stands
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdData_r <= READ_ZERO;
    end else if (busReq && !ack_r) begin
      rdData_r <= wbReq.we ? READ_ZERO : rdMux;
    end
  end

  assign wbRsp = '{ack: ack_r, dat: rdData_r};

  // control register: stop field goes to the sequencer, not stored here
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wakeModeSelect_r <= BYTE_RESET[CTRL_WAKE_MODE_BIT];
    end else if (wrCtrl) begin
      wakeModeSelect_r <= wrByte[CTRL_WAKE_MODE_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      channelSourceSelect_r <= BYTE_RESET[CTRL_SRC_SEL_BIT];
    end else if (wrCtrl) begin
      channelSourceSelect_r <= wrByte[CTRL_SRC_SEL_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lineMask_r <= LINES_RESET;
    end else if (wrMaskH) begin
      lineMask_r <= mergeByte(lineMask_r, wrByte, 1'b1);
    end else if (wrMaskL) begin
      lineMask_r <= mergeByte(lineMask_r, wrByte, 1'b0);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      linePolarity_r <= LINES_RESET;
    end else if (wrPolH) begin
      linePolarity_r <= mergeByte(linePolarity_r, wrByte, 1'b1);
    end else if (wrPolL) begin
      linePolarity_r <= mergeByte(linePolarity_r, wrByte, 1'b0);
    end
  end

  // wake lines and the single pin pass the synchroniser first
  wuim_pin_sync #(
    .WIDTH(LINE_COUNT)
  ) u_line_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pinAsync(wakeLinePins),
    .pinLevel(lineLevel),
    .pinRise(lineRise),
    .pinFall(lineFall)
  );

  wuim_pin_sync #(
    .WIDTH(1)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pinAsync(singleExtIrqPin),
    .pinLevel(extPinLevel),
    .pinRise(),
    .pinFall()
  );

  // edge selected by polarity; dropped while a polarity register is written
  assign polarityWriting = wrPolH | wrPolL;
  assign hwSet = ((linePolarity_r & lineRise) | (~linePolarity_r & lineFall))
                 & {LINE_COUNT{~polarityWriting}};

  always_comb begin
    pendingSw = linePending_r;
    if (wrPendH) begin
      pendingSw = mergeByte(pendingSw, wrByte, 1'b1);
    end
    if (wrPendL) begin
      pendingSw = mergeByte(pendingSw, wrByte, 1'b0);
    end
    // hardware set wins over a software clear in the same cycle
    linePending_nxt = pendingSw | hwSet;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      linePending_r <= LINES_RESET;
    end else begin
      linePending_r <= linePending_nxt;
    end
  end

  // while the lines feed the channel, a software clear of any unmasked bit drops it for one cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      clearGap_r <= 1'b0;
    end else begin
      clearGap_r <= |(linePending_r & ~pendingSw & lineMask_r);
    end
  end

  assign unmaskedPending = lineMask_r & linePending_r;
  assign anyUnmasked = |unmaskedPending;

  assign channelLevel = channelSourceSelect_r ? anyUnmasked : extPinLevel;
  assign wakeEvent = wakeModeSelect_r & anyUnmasked;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      channelIrq_r <= 1'b0;
    end else begin
      // the gap only applies while the lines feed the channel
      channelIrq_r <= channelLevel & ~(clearGap_r & channelSourceSelect_r);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wakeEventOut_r <= 1'b0;
    end else begin
      wakeEventOut_r <= wakeEvent;
    end
  end

  assign sharedExtIrqChannel = channelIrq_r;
  assign wakeEventOut = wakeEventOut_r;

  // stop sequence: entry conditions and aborting writes
  assign entryAllowed = wakeModeSelect_r & ~anyUnmasked & (|lineMask_r);
  assign otherWrite = (busWrite & ~hitCtrl) | extRegWrite;

  wuim_stop_seq u_stop_seq (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ctrlWrite(busWrite & hitCtrl),
    .ctrlStopData(wrByte[CTRL_STOP_BIT] & wbReq.sel[0]),
    .otherWrite(otherWrite),
    .entryAllowed(entryAllowed),
    .wakeEvent(wakeEvent),
    .stopBit(stopBit),
    .stopRequest(stopRequest)
  );

  assign resetClockUnitStopReq = stopRequest;

endmodule : wuim_manager
`default_nettype wire

// [tb/wuim_manager_assertions.sv]
// port checker for the wake-up interrupt manager
`timescale 1ns/1ps
`default_nettype none
module wuim_manager_assertions (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire wuim_pkg::wuim_wb_req_t wbReq,
  input wire wuim_pkg::wuim_wb_rsp_t wbRsp,
  input wire logic [wuim_pkg::LINE_COUNT-1:0] wakeLinePins,
  input wire logic singleExtIrqPin,
  input wire logic extRegWrite,
  input wire logic sharedExtIrqChannel,
  input wire logic wakeEventOut,
  input wire logic resetClockUnitStopReq
);
  import wuim_pkg::*;
  logic wrAck;
  logic [IDX_W-1:0] idx;
  logic [1:0] ctrl_r;
  logic [15:0] mask_r;
  assign idx = wbReq.adr[ADR_W-1:WORD_LSB];
  assign wrAck = wbRsp.ack & wbReq.cyc & wbReq.we;
  // shadow copies of mode, source select and mask
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_r <= 2'h0;
    end else if (wrAck && wbReq.sel[0] && idx == IDX_CONTROL) begin
      ctrl_r <= wbReq.dat[1:0];
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mask_r <= 16'h0000;
    end else if (wrAck && wbReq.sel[0] && idx == IDX_MASK_HIGH) begin
      mask_r[15:8] <= wbReq.dat[7:0];
    end else if (wrAck && wbReq.sel[0] && idx == IDX_MASK_LOW) begin
      mask_r[7:0] <= wbReq.dat[7:0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_quiet;
    !$past(wrAck) && !$past(extRegWrite);
  endsequence
  a_ack_next: assert property (wbReq.cyc && wbReq.stb && !wbRsp.ack |=> wbRsp.ack)
    else $error("ack did not follow a request");
  a_ack_single: assert property (wbRsp.ack |=> !wbRsp.ack)
    else $error("ack longer than one cycle");
  a_read_upper: assert property (wbRsp.ack |-> wbRsp.dat[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_entry_quiet: assert property ($rose(resetClockUnitStopReq) |-> s_quiet)
    else $error("stop entered right after a write");
  a_entry_cond: assert property ($rose(resetClockUnitStopReq) |-> ctrl_r[0] && mask_r != 0)
    else $error("stop entered without mode or mask");
  a_wake_ends: assert property (resetClockUnitStopReq && wakeEventOut |-> ##[0:2] !resetClockUnitStopReq)
    else $error("wake event did not end stop");
  a_mode_gate: assert property ((!ctrl_r[0])[*3] |-> !wakeEventOut)
    else $error("wake event outside wake mode");
  a_mask_wake: assert property ((mask_r == 16'h0000)[*3] |-> !wakeEventOut)
    else $error("wake event with all lines masked");
  a_mask_irq: assert property ((mask_r == 16'h0000 && ctrl_r[1])[*3] |-> !sharedExtIrqChannel)
    else $error("channel raised with all lines masked");
  a_pin_drives: assert property ((!ctrl_r[1] && $stable(singleExtIrqPin))[*8] |-> sharedExtIrqChannel == singleExtIrqPin)
    else $error("channel does not follow the external pin");
endmodule : wuim_manager_assertions
`default_nettype wire

// [tb/wuim_pin_model.sv]
// far side: wake lines, external pin and the clock unit's stop view
`timescale 1ns/1ps
`default_nettype none
module wuim_pin_model (
  input wire logic ref_clk,
  input wire logic [15:0] lineTarget,
  input wire logic pinTarget,
  input wire logic stopReq,
  output logic [15:0] wakeLinePins,
  output logic singleExtIrqPin,
  output int stopCycles
);
  initial begin
    wakeLinePins = 16'h0000;
    singleExtIrqPin = 1'h0;
    stopCycles = 0;
  end
  // lines move only on clock edges and are held clean for many cycles
  always @(posedge ref_clk) begin
    wakeLinePins <= lineTarget;
    singleExtIrqPin <= pinTarget;
    if (stopReq) begin
      stopCycles <= stopCycles + 1;
    end
  end
endmodule : wuim_pin_model
`default_nettype wire

// [tb/wuim_manager_test.sv]
// self-checking bench for the wake-up interrupt manager
`timescale 1ns/1ps
`default_nettype none
module wuim_manager_test;
  import wuim_pkg::*;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  wuim_wb_req_t wbReq = '0;
  wuim_wb_rsp_t wbRsp;
  logic [15:0] pins;
  logic [15:0] lineTarget = 16'h0000;
  logic extPin;
  logic pinTarget = 1'h0;
  logic extRegWrite = 1'h0;
  logic chan;
  logic wakeEv;
  logic stopReq;
  logic armDrop = 1'h0;
  logic sawDrop = 1'h0;
  logic [7:0] q;
  int stopCycles;
  int badCount = 0;
  int nChecks = 0;
  int mask;
  int pol;
  int pend;
  bit hit;
  wuim_manager dut (.ref_clk(ref_clk), .rst_n(rst_n), .wbReq(wbReq), .wbRsp(wbRsp),
    .wakeLinePins(pins), .singleExtIrqPin(extPin), .extRegWrite(extRegWrite),
    .sharedExtIrqChannel(chan), .wakeEventOut(wakeEv), .resetClockUnitStopReq(stopReq));
  wuim_pin_model far (.ref_clk(ref_clk), .lineTarget(lineTarget), .pinTarget(pinTarget),
    .stopReq(stopReq), .wakeLinePins(pins), .singleExtIrqPin(extPin), .stopCycles(stopCycles));
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (armDrop && !chan) begin
      sawDrop <= 1'h1;
    end
  end
  task automatic closeOut();
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : closeOut
  task automatic chk(input string m, input logic [7:0] got, input int exp);
    nChecks++;
    if (got !== exp[7:0]) begin
      badCount++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic bus(input logic [IDX_W-1:0] idx, input logic w, input int d);
    int n;
    n = 0;
    wbReq <= '{1'h1, 1'h1, w, {idx, 2'h0}, 4'hF, {24'h000000, d[7:0]}};
    @(posedge ref_clk);
    while (wbRsp.ack !== 1'h1) begin
      n++;
      if (n > 20) begin
        chk("bus timeout", 8'h00, 1);
        closeOut();
      end
      @(posedge ref_clk);
    end
    q = wbRsp.dat[7:0];
    wbReq <= '0;
    @(posedge ref_clk);
  endtask : bus
  task automatic rd(input logic [IDX_W-1:0] idx, input int exp);
    bus(idx, 1'h0, 0);
    chk("register read", q, exp);
  endtask : rd
  task automatic rd16(input logic [IDX_W-1:0] hi, input int exp);
    rd(hi, exp >> 8);
    rd(hi + 8'h01, exp);
  endtask : rd16
  task automatic wr16(input logic [IDX_W-1:0] hi, input int v);
    bus(hi, 1'h1, v >> 8);
    bus(hi + 8'h01, 1'h1, v);
  endtask : wr16
  task automatic toggle(input int i);
    if (lineTarget[i] !== pol[i]) begin
      pend = pend | (1 << i);
    end
    lineTarget[i] <= ~lineTarget[i];
    repeat (12) @(posedge ref_clk);
  endtask : toggle
  task automatic waitFor(input logic want, input int lim);
    hit = 0;
    for (int n = 0; n < lim && !hit; n++) begin
      @(posedge ref_clk);
      hit = (stopReq === want);
    end
  endtask : waitFor
  initial begin
    void'($urandom(61));
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'h1;
    @(posedge ref_clk);
    rd16(IDX_MASK_HIGH, 0);
    rd16(IDX_POL_HIGH, 0);
    rd16(IDX_PEND_HIGH, 0);
    rd16(IDX_LINE_STATE_HIGH, 0);
    rd(IDX_CONTROL, 0);
    bus(8'h10, 1'h1, 8'hFF);
    rd(8'h10, 0);
    $display("test reset values done");
    mask = ($urandom & 16'hFFFF) | 1;
    pol = $urandom & 16'hFFFF;
    pend = 0;
    wr16(IDX_MASK_HIGH, mask);
    wr16(IDX_POL_HIGH, pol);
    rd16(IDX_MASK_HIGH, mask);
    rd16(IDX_POL_HIGH, pol);
    for (int t = 0; t < 10; t++) begin
      toggle($urandom % 16);
      rd16(IDX_PEND_HIGH, pend);
      rd16(IDX_LINE_STATE_HIGH, lineTarget);
    end
    pend = pend | 16'h8001;
    wr16(IDX_PEND_HIGH, pend);
    rd16(IDX_PEND_HIGH, pend);
    bus(IDX_PEND_HIGH, 1'h0, 0);
    bus(IDX_PEND_HIGH, 1'h1, q & 8'h7F);
    pend = pend & 16'h7FFF;
    rd16(IDX_PEND_HIGH, pend);
    $display("test edge capture done");
    wr16(IDX_MASK_HIGH, 3);
    wr16(IDX_PEND_HIGH, 1);
    for (int c = 0; c < 4; c++) begin
      bus(IDX_CONTROL, 1'h1, c);
      repeat (3) @(posedge ref_clk);
      chk("channel", chan, c >> 1);
      chk("wake event", wakeEv, c & 1);
    end
    wr16(IDX_MASK_HIGH, 0);
    repeat (3) @(posedge ref_clk);
    chk("masked channel", chan, 0);
    chk("masked wake", wakeEv, 0);
    bus(IDX_CONTROL, 1'h1, 0);
    pinTarget <= 1'h1;
    repeat (10) @(posedge ref_clk);
    chk("pin channel", chan, 1);
    pinTarget <= 1'h0;
    wr16(IDX_MASK_HIGH, 3);
    wr16(IDX_PEND_HIGH, 3);
    bus(IDX_CONTROL, 1'h1, 2);
    @(posedge ref_clk);
    armDrop <= 1'h1;
    bus(IDX_PEND_LOW, 1'h1, 2);
    repeat (6) @(posedge ref_clk);
    armDrop <= 1'h0;
    chk("fresh edge", sawDrop, 1);
    chk("channel back", chan, 1);
    $display("test channel routing done");
    pend = 0;
    pol = lineTarget[0] ? 0 : 1;
    wr16(IDX_POL_HIGH, pol);
    wr16(IDX_PEND_HIGH, 0);
    bus(IDX_CONTROL, 1'h1, 5);
    rd(IDX_CONTROL, 5);
    bus(IDX_CONTROL, 1'h1, 1);
    bus(IDX_CONTROL, 1'h1, 5);
    rd(IDX_CONTROL, 5);
    waitFor(1'h1, 20);
    chk("stop entered", hit, 1);
    toggle(0);
    chk("clock unit stopped", stopCycles > 0, 1);
    waitFor(1'h0, 20);
    chk("stop left", hit, 1);
    rd(IDX_CONTROL, 1);
    for (int v = 0; v < 5; v++) begin
      wr16(IDX_PEND_HIGH, v == 3);
      bus(IDX_CONTROL, 1'h1, v == 2 ? 4 : 5);
      if (v == 0) begin
        extRegWrite <= 1'h1;
        @(posedge ref_clk);
        extRegWrite <= 1'h0;
      end
      if (v == 1) wr16(IDX_MASK_HIGH, 3);
      bus(IDX_CONTROL, 1'h1, v == 2 ? 0 : 1);
      bus(IDX_CONTROL, 1'h1, v == 2 ? 4 : 5);
      if (v == 4) wr16(IDX_MASK_HIGH, 3);
      waitFor(1'h1, 15);
      chk("stop refused", hit, 0);
      if (v > 1) rd(IDX_CONTROL, v == 2 ? 0 : 1);
      bus(IDX_CONTROL, 1'h1, 0);
    end
    $display("test stop sequence done");
    pol = lineTarget[1] ? 0 : 2;
    wr16(IDX_POL_HIGH, pol);
    wr16(IDX_PEND_HIGH, 0);
    lineTarget[1] <= ~lineTarget[1];
    repeat (4) @(posedge ref_clk);
    bus(IDX_POL_LOW, 1'h1, pol);
    repeat (8) @(posedge ref_clk);
    rd(IDX_PEND_LOW, 0);
    $display("test polarity write done");
    closeOut();
  end
endmodule : wuim_manager_test
bind wuim_manager wuim_manager_assertions chkr (.ref_clk(ref_clk), .rst_n(rst_n),
  .wbReq(wbReq), .wbRsp(wbRsp), .wakeLinePins(wakeLinePins),
  .singleExtIrqPin(singleExtIrqPin), .extRegWrite(extRegWrite),
  .sharedExtIrqChannel(sharedExtIrqChannel), .wakeEventOut(wakeEventOut),
  .resetClockUnitStopReq(resetClockUnitStopReq));
`default_nettype wire
